/* design/sfc_sideband_flow_control.sv */
// sideband flow control: calendar transmitter and receiver user side
//
// Function
// - transmitter starts framing right after reset release
// - status frames are sent only while some health input is low
// - while unhealthy, status frames alternate with calendar frames
// - with all health inputs high only calendars are sent
// - calendar length from length-minus-one input, bit 0 sent first
// - flow bits latched per 64-bit group on update k, health on group 0
// - receiver outputs zero flow bits until several good syncs seen
// - two back-to-back good calendars without status mean healthy
// - first received calendar entry lands on output bit 0
// - unhealthy status forces flow bits off, healthy restores them
// - crc mismatch raises the error flag; with force input low it holds all outputs
// - overflow flag rises when user clock is too slow for the link
// - any length up to the maximum accepted, last length reported
// - flow output refreshed per 64-bit group with an update pulse
// - flow bit 1 means transmit on, 0 transmit off, bit k channel k
// - force input turns all flow bits off while a crc error stands
`timescale 1ns/1ps
`default_nettype none
module sfc_sideband_flow_control (
	input  wire logic          CLOCK_I,
	input  wire logic          RESETN_I,
	input  wire logic [127:0]  TX_FLOW_BITS_I,
	input  wire logic [1:0]    TX_UPDATE_I,
	input  wire logic [6:0]    TX_CALENDAR_LENGTH_M1_I,
	input  wire logic          TX_INTF_STATUS_I,
	input  wire logic [3:0]    TX_LANE_STATUS_I,
	output logic               LINK_TX_CLOCK_O,
	output logic               LINK_TX_SERIAL_DATA_O,
	output logic               LINK_TX_FRAME_SYNC_O,
	input  wire logic          LINK_RX_CLOCK_I,
	input  wire logic          LINK_RX_SERIAL_DATA_I,
	input  wire logic          LINK_RX_FRAME_SYNC_I,
	input  wire logic          RX_FORCE_OFF_ON_CRCERR_I,
	output logic [127:0]       RX_FLOW_BITS_O,
	output logic               RX_CRC_ERROR_O,
	output logic               RX_OVERFLOW_O,
	output logic               RX_INTF_STATUS_O,
	output logic [3:0]         RX_LANE_STATUS_O,
	output logic [1:0]         RX_UPDATE_O,
	output logic [6:0]         RX_CALENDAR_LENGTH_M1_O,
	output logic               RX_INITIALIZED_O
);
	// transmit bit clock
	logic [1:0] tx_ph_q;
	wire        tx_tick_w = tx_ph_q == 2'(2 * sfc_pkg::TX_HALF_CYC - 1);
	always_ff @(posedge CLOCK_I) begin
		if (!RESETN_I) begin
			tx_ph_q <= 2'h0;
			LINK_TX_CLOCK_O <= 1'b0;
		end else begin
			tx_ph_q <= tx_tick_w ? 2'h0 : tx_ph_q + 2'h1;
			if (tx_ph_q == 2'(sfc_pkg::TX_HALF_CYC - 1)) begin
				LINK_TX_CLOCK_O <= 1'b1;
			end else if (tx_tick_w) begin
				LINK_TX_CLOCK_O <= 1'b0;
			end
		end
	end

	// transmit latches
	logic [127:0] tx_cal_q;
	logic         tx_h_intf_q;
	logic [3:0]   tx_h_lanes_q;
	genvar g;
	generate
		for (g = 0; g < sfc_pkg::GROUPS; g++) begin : gen_txlat
			always_ff @(posedge CLOCK_I) begin
				if (!RESETN_I) begin
					tx_cal_q[g*64 +: 64] <= 64'h0;
				end else if (TX_UPDATE_I[g]) begin
					tx_cal_q[g*64 +: 64] <= TX_FLOW_BITS_I[g*64 +: 64];
				end
			end
		end
	endgenerate
	always_ff @(posedge CLOCK_I) begin
		if (!RESETN_I) begin
			tx_h_intf_q <= 1'b1;
			tx_h_lanes_q <= 4'hf;
		end else if (TX_UPDATE_I[0]) begin
			tx_h_intf_q <= TX_INTF_STATUS_I;
			tx_h_lanes_q <= TX_LANE_STATUS_I;
		end
	end
	wire tx_unhealthy_w = !tx_h_intf_q || !(&tx_h_lanes_q);

	// transmit framer
	sfc_pkg::sfc_bit_state_t tx_st_q, tx_st_d;
	logic [2:0] tx_cnt_q, tx_cnt_d;
	logic [6:0] tx_idx_q, tx_idx_d, tx_len_q, tx_len_d;
	logic [3:0] tx_crc_q, tx_crc_d;
	logic       tx_sta_q, tx_sta_d, tx_last_q, tx_last_d;
	logic       tx_s_intf_q, tx_s_intf_d;
	logic [3:0] tx_s_lanes_q, tx_s_lanes_d;
	wire  [7:0] tx_hdr_w = {sfc_pkg::KIND_CAL, tx_len_q};
	wire  [5:0] tx_stv_w = {sfc_pkg::KIND_STA, tx_s_intf_q, tx_s_lanes_q};
	wire        tx_hdr_bit_w = tx_hdr_w[3'(sfc_pkg::HDR_BITS - 1) - tx_cnt_q];
	wire        tx_sta_bit_w = tx_stv_w[3'(sfc_pkg::STA_BITS - 1) - tx_cnt_q];
	wire        tx_crc_bit_w = tx_crc_q[2'(sfc_pkg::CRC_W - 1) - tx_cnt_q[1:0]];
	wire        tx_cal_bit_w = tx_cal_q[tx_idx_q];
	wire        tx_bit_w = (tx_st_q == sfc_pkg::SFC_HDR) ? tx_hdr_bit_w :
		(tx_st_q == sfc_pkg::SFC_CAL) ? tx_cal_bit_w :
		(tx_st_q == sfc_pkg::SFC_STA) ? tx_sta_bit_w : tx_crc_bit_w;
	wire        tx_sync_w = (tx_st_q == sfc_pkg::SFC_HDR ||
		tx_st_q == sfc_pkg::SFC_STA) && tx_cnt_q == 3'h0;
	wire        tx_crc_end_w = tx_st_q == sfc_pkg::SFC_CRC &&
		tx_cnt_q == 3'(sfc_pkg::CRC_W - 1);

	always_comb begin
		tx_st_d = tx_st_q;
		tx_cnt_d = tx_cnt_q + 3'h1;
		tx_idx_d = tx_idx_q;
		tx_len_d = tx_len_q;
		tx_sta_d = tx_sta_q;
		tx_last_d = tx_last_q;
		tx_s_intf_d = tx_s_intf_q;
		tx_s_lanes_d = tx_s_lanes_q;
		tx_crc_d = sfc_pkg::crc4_step(tx_crc_q, tx_bit_w);
		case (tx_st_q)
			sfc_pkg::SFC_HDR: begin
				if (tx_cnt_q == 3'h0) begin
					tx_len_d = TX_CALENDAR_LENGTH_M1_I;
				end
				if (tx_cnt_q == 3'(sfc_pkg::HDR_BITS - 1)) begin
					tx_st_d = sfc_pkg::SFC_CAL;
					tx_idx_d = 7'h00;
				end
			end
			sfc_pkg::SFC_CAL: begin
				tx_idx_d = tx_idx_q + 7'h01;
				if (tx_idx_q == tx_len_q || tx_idx_q[5:0] == 6'h3f) begin
					tx_st_d = sfc_pkg::SFC_CRC;
					tx_cnt_d = 3'h0;
					tx_last_d = tx_idx_q == tx_len_q;
				end
			end
			sfc_pkg::SFC_STA: begin
				if (tx_cnt_q == 3'h0) begin
					tx_s_intf_d = tx_h_intf_q;
					tx_s_lanes_d = tx_h_lanes_q;
				end
				if (tx_cnt_q == 3'(sfc_pkg::STA_BITS - 1)) begin
					tx_st_d = sfc_pkg::SFC_CRC;
					tx_cnt_d = 3'h0;
					tx_last_d = 1'b1;
				end
			end
			default: begin
				tx_crc_d = tx_crc_q;
				if (tx_crc_end_w) begin
					tx_crc_d = sfc_pkg::CRC_INIT;
					tx_cnt_d = 3'h0;
					if (!tx_last_q) begin
						tx_st_d = sfc_pkg::SFC_CAL;
					end else if (!tx_sta_q && tx_unhealthy_w) begin
						tx_st_d = sfc_pkg::SFC_STA;
						tx_sta_d = 1'b1;
					end else begin
						tx_st_d = sfc_pkg::SFC_HDR;
						tx_sta_d = 1'b0;
					end
				end
			end
		endcase
	end

	always_ff @(posedge CLOCK_I) begin
		if (!RESETN_I) begin
			tx_st_q <= sfc_pkg::SFC_HDR;
			tx_cnt_q <= 3'h0;
			tx_idx_q <= 7'h00;
			tx_len_q <= 7'h00;
			tx_crc_q <= sfc_pkg::CRC_INIT;
			tx_sta_q <= 1'b0;
			tx_last_q <= 1'b0;
			tx_s_intf_q <= 1'b1;
			tx_s_lanes_q <= 4'hf;
			LINK_TX_SERIAL_DATA_O <= 1'b0;
			LINK_TX_FRAME_SYNC_O <= 1'b0;
		end else if (tx_tick_w) begin
			tx_st_q <= tx_st_d;
			tx_cnt_q <= tx_cnt_d;
			tx_idx_q <= tx_idx_d;
			tx_len_q <= tx_len_d;
			tx_crc_q <= tx_crc_d;
			tx_sta_q <= tx_sta_d;
			tx_last_q <= tx_last_d;
			tx_s_intf_q <= tx_s_intf_d;
			tx_s_lanes_q <= tx_s_lanes_d;
			LINK_TX_SERIAL_DATA_O <= tx_bit_w;
			LINK_TX_FRAME_SYNC_O <= tx_sync_w;
		end
	end

	// receiver link side
	logic        req_tog_w, ovf_tog_w, ack_tog_q;
	logic        w_kind_w, w_last_w, w_grp_w, w_crc_ok_w, w_aligned_w;
	logic [63:0] w_payload_w;
	logic [6:0]  w_len_w;
	logic        w_intf_w;
	logic [3:0]  w_lanes_w;
	sfc_rx_deser u_deser (
		.link_clock_i  (LINK_RX_CLOCK_I),
		.resetn_i      (RESETN_I),
		.serial_data_i (LINK_RX_SERIAL_DATA_I),
		.frame_sync_i  (LINK_RX_FRAME_SYNC_I),
		.ack_toggle_i  (ack_tog_q),
		.req_toggle_o  (req_tog_w),
		.ovf_toggle_o  (ovf_tog_w),
		.w_kind_o      (w_kind_w),
		.w_last_o      (w_last_w),
		.w_grp_o       (w_grp_w),
		.w_crc_ok_o    (w_crc_ok_w),
		.w_aligned_o   (w_aligned_w),
		.w_payload_o   (w_payload_w),
		.w_len_o       (w_len_w),
		.w_intf_o      (w_intf_w),
		.w_lanes_o     (w_lanes_w)
	);

	// toggle crossings into the user clock
	wire  [1:0] cx_in_w = {ovf_tog_w, req_tog_w};
	logic [1:0] cx1_q, cx2_q, cx3_q, cxf_q;
	wire  [1:0] cx_evt_w;
	generate
		for (g = 0; g < 2; g++) begin : gen_cross
			assign cx_evt_w[g] = (cx2_q[g] == cx3_q[g]) &&
				(cx3_q[g] != cxf_q[g]);
			always_ff @(posedge CLOCK_I) begin
				cx1_q[g] <= cx_in_w[g];
				cx2_q[g] <= cx1_q[g];
				cx3_q[g] <= cx2_q[g];
				if (!RESETN_I) begin
					cxf_q[g] <= 1'b0;
				end else if (cx2_q[g] == cx3_q[g]) begin
					cxf_q[g] <= cx3_q[g];
				end
			end
		end
	endgenerate
	wire w_evt_w = cx_evt_w[0];
	wire ovf_evt_w = cx_evt_w[1];
	wire w_first_w = w_kind_w == sfc_pkg::KIND_STA || !w_grp_w;

	// receiver user side
	logic [127:0] cal_q, cal_d;
	logic [1:0]   scnt_q, scnt_d, upd_d;
	logic         init_q, init_d, crcerr_d, healthy_q, healthy_d;
	logic         intf_d, run_q, run_d;
	logic [3:0]   lanes_d;
	logic [6:0]   len_d;
	always_comb begin
		cal_d = cal_q;
		scnt_d = scnt_q;
		upd_d = 2'h0;
		init_d = init_q;
		crcerr_d = RX_CRC_ERROR_O;
		healthy_d = healthy_q;
		intf_d = RX_INTF_STATUS_O;
		lanes_d = RX_LANE_STATUS_O;
		run_d = run_q;
		len_d = RX_CALENDAR_LENGTH_M1_O;
		if (w_evt_w) begin
			crcerr_d = !w_crc_ok_w;
			if (!w_crc_ok_w) begin
				run_d = 1'b0;
			end
			if (!init_q && w_first_w) begin
				if (w_aligned_w && w_crc_ok_w) begin
					scnt_d = scnt_q + 2'h1;
					init_d = scnt_q == 2'(sfc_pkg::INIT_SYNCS - 1);
				end else begin
					scnt_d = 2'h0;
				end
			end
			if (init_q && w_crc_ok_w && w_kind_w == sfc_pkg::KIND_STA) begin
				intf_d = w_intf_w;
				lanes_d = w_lanes_w;
				healthy_d = w_intf_w && (&w_lanes_w);
				run_d = 1'b0;
			end else if (init_q && w_crc_ok_w) begin
				cal_d[w_grp_w*64 +: 64] = w_payload_w;
				upd_d[w_grp_w] = 1'b1;
				len_d = w_len_w;
				if (w_last_w && run_q == 1'(sfc_pkg::HEALTHY_CALS - 1)) begin
					healthy_d = 1'b1;
					intf_d = 1'b1;
					lanes_d = 4'hf;
				end else if (w_last_w) begin
					run_d = 1'b1;
				end
			end
		end
	end
	wire show_w = init_d && healthy_d &&
		!(RX_FORCE_OFF_ON_CRCERR_I && crcerr_d);

	always_ff @(posedge CLOCK_I) begin
		if (!RESETN_I) begin
			cal_q <= 128'h0;
			scnt_q <= 2'h0;
			init_q <= 1'b0;
			healthy_q <= 1'b0;
			run_q <= 1'b0;
			ack_tog_q <= 1'b0;
			RX_FLOW_BITS_O <= 128'h0;
			RX_CRC_ERROR_O <= 1'b0;
			RX_OVERFLOW_O <= 1'b0;
			RX_INTF_STATUS_O <= 1'b0;
			RX_LANE_STATUS_O <= 4'h0;
			RX_UPDATE_O <= 2'h0;
			RX_CALENDAR_LENGTH_M1_O <= 7'h00;
			RX_INITIALIZED_O <= 1'b0;
		end else begin
			cal_q <= cal_d;
			scnt_q <= scnt_d;
			init_q <= init_d;
			healthy_q <= healthy_d;
			run_q <= run_d;
			ack_tog_q <= ack_tog_q ^ w_evt_w;
			RX_FLOW_BITS_O <= show_w ? cal_d : 128'h0;
			RX_CRC_ERROR_O <= crcerr_d;
			RX_OVERFLOW_O <= RX_OVERFLOW_O | ovf_evt_w;
			RX_INTF_STATUS_O <= intf_d;
			RX_LANE_STATUS_O <= lanes_d;
			RX_UPDATE_O <= upd_d;
			RX_CALENDAR_LENGTH_M1_O <= len_d;
			RX_INITIALIZED_O <= init_d;
		end
	end

	default clocking cb @(posedge CLOCK_I);
	endclocking
	default disable iff (!RESETN_I);

	a_tx_starts: assert property (
		$rose(RESETN_I) |-> ##[1:6] LINK_TX_FRAME_SYNC_O)
		else $error("no frame sync after reset release");
	a_status_unhealthy: assert property (
		$rose(tx_sta_q) |-> $past(tx_unhealthy_w))
		else $error("status frame started while healthy");
	a_status_alternate: assert property (
		(tx_tick_w && tx_crc_end_w && tx_sta_q) |=>
		(tx_st_q == sfc_pkg::SFC_HDR && !tx_sta_q))
		else $error("status frame not followed by a calendar");
	a_cal_order: assert property (
		(tx_tick_w && tx_st_q == sfc_pkg::SFC_CAL) |=>
		LINK_TX_SERIAL_DATA_O == $past(tx_cal_q[tx_idx_q]))
		else $error("calendar bit out of order");
	a_init_off: assert property (
		!RX_INITIALIZED_O |-> RX_FLOW_BITS_O == 128'h0)
		else $error("flow bits on before initialisation");
	a_unhealthy_off: assert property (
		!RX_INTF_STATUS_O || !(&RX_LANE_STATUS_O) |->
		RX_FLOW_BITS_O == 128'h0)
		else $error("flow bits on while unhealthy");
	a_crc_hold: assert property (
		(w_evt_w && !w_crc_ok_w && !RX_FORCE_OFF_ON_CRCERR_I) |=>
		(RX_CRC_ERROR_O && $stable(RX_FLOW_BITS_O) &&
		$stable(RX_INTF_STATUS_O) && RX_UPDATE_O == 2'h0))
		else $error("outputs changed on crc error");
	a_force_off: assert property (
		(crcerr_d && RX_FORCE_OFF_ON_CRCERR_I) |=>
		RX_FLOW_BITS_O == 128'h0)
		else $error("flow bits not forced off on crc error");
	a_healthy_two: assert property (
		(w_evt_w && init_q && w_crc_ok_w && w_last_w && run_q &&
		w_kind_w == sfc_pkg::KIND_CAL) |=>
		(RX_INTF_STATUS_O && RX_LANE_STATUS_O == 4'hf))
		else $error("not healthy after two calendars");
	a_update_pulse: assert property (
		(|RX_UPDATE_O) |=> RX_UPDATE_O == 2'h0)
		else $error("update held longer than one cycle");
	a_overflow_flag: assert property (
		ovf_evt_w |=> RX_OVERFLOW_O)
		else $error("overflow not reported");

	c_status_sent: cover property ($rose(tx_sta_q));
	c_initialised: cover property ($rose(RX_INITIALIZED_O));
	c_crc_error: cover property ($rose(RX_CRC_ERROR_O));
	c_healthy: cover property ($rose(RX_INTF_STATUS_O));
endmodule
`default_nettype wire

/* shared/sfc_pkg.sv */
// shared constants, types and crc helper for the sideband flow control block
package sfc_pkg;
	localparam int CAL_MAX      = 128;
	localparam int GROUP_BITS   = 64;
	localparam int GROUPS       = 2;
	localparam int LANES        = 4;
	localparam int LEN_W        = 7;
	localparam int CRC_W        = 4;
	localparam int HDR_BITS     = 8;
	localparam int STA_BITS     = 6;
	localparam int INIT_SYNCS   = 4;
	localparam int HEALTHY_CALS = 2;
	localparam logic [3:0] CRC_INIT = 4'hf;
	localparam logic [3:0] CRC_POLY = 4'h3;
	localparam logic       KIND_CAL = 1'b0;
	localparam logic       KIND_STA = 1'b1;
	// link transmit clock timing
	localparam int CLOCK_PERIOD_NS   = 25;
	localparam int LINK_TX_PERIOD_NS = 100;
	localparam int TX_HALF_CYC = LINK_TX_PERIOD_NS / (2 * CLOCK_PERIOD_NS);

	typedef enum logic [2:0] {
		SFC_HDR  = 3'b000,
		SFC_CAL  = 3'b001,
		SFC_CRC  = 3'b010,
		SFC_STA  = 3'b011,
		SFC_HUNT = 3'b100
	} sfc_bit_state_t;

	// serial crc4, x^4 + x + 1, msb first
	function automatic logic [3:0] crc4_step(input logic [3:0] crc,
		input logic b);
		logic fb;
		fb = crc[3] ^ b;
		return {crc[2:0], 1'b0} ^ (fb ? CRC_POLY : 4'h0);
	endfunction
endpackage

/* design/sfc_rx_deser.sv */
// link clock side of the receiver: deserialiser and word handshake
`timescale 1ns/1ps
`default_nettype none
module sfc_rx_deser (
	input  wire logic        link_clock_i,
	input  wire logic        resetn_i,
	input  wire logic        serial_data_i,
	input  wire logic        frame_sync_i,
	input  wire logic        ack_toggle_i,
	output logic             req_toggle_o,
	output logic             ovf_toggle_o,
	output logic             w_kind_o,
	output logic             w_last_o,
	output logic             w_grp_o,
	output logic             w_crc_ok_o,
	output logic             w_aligned_o,
	output logic [63:0]      w_payload_o,
	output logic [6:0]       w_len_o,
	output logic             w_intf_o,
	output logic [3:0]       w_lanes_o
);
	logic                  d_q, s_q;
	logic                  rs1_q, rs2_q, rs3_q, rst_n_q;
	logic                  a1_q, a2_q, a3_q, ack_q;
	sfc_pkg::sfc_bit_state_t st_q, st_d;
	logic [2:0]            cnt_q, cnt_d;
	logic [6:0]            idx_q, idx_d, len_q, len_d, sh_q, sh_d;
	logic [2:0]            rc_q, rc_d;
	logic [3:0]            crc_q, crc_d;
	logic [63:0]           pay_q, pay_d;
	logic                  expect_q, expect_d, aligned_q, aligned_d;
	logic                  grp_q, grp_d, last_q, last_d;
	logic                  emit_d, crc_ok_d;
	logic                  sta_q;
	wire                   busy_w = req_toggle_o != ack_q;

	// sampling, reset and ack synchronisers on the link clock
	always_ff @(posedge link_clock_i) begin
		d_q <= serial_data_i;
		s_q <= frame_sync_i;
		rs1_q <= resetn_i;
		rs2_q <= rs1_q;
		rs3_q <= rs2_q;
		rst_n_q <= (rs2_q == rs3_q) ? rs3_q : rst_n_q;
		a1_q <= ack_toggle_i;
		a2_q <= a1_q;
		a3_q <= a2_q;
		ack_q <= (a2_q == a3_q) ? a3_q : ack_q;
	end

	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		idx_d = idx_q;
		len_d = len_q;
		sh_d = sh_q;
		rc_d = rc_q;
		crc_d = crc_q;
		pay_d = pay_q;
		expect_d = expect_q;
		aligned_d = aligned_q;
		grp_d = grp_q;
		last_d = last_q;
		emit_d = 1'b0;
		crc_ok_d = 1'b0;
		if (s_q) begin
			aligned_d = (st_q == sfc_pkg::SFC_HUNT) && expect_q;
			crc_d = sfc_pkg::crc4_step(sfc_pkg::CRC_INIT, d_q);
			cnt_d = 3'h0;
			idx_d = 7'h00;
			expect_d = 1'b0;
			if (d_q == sfc_pkg::KIND_STA) begin
				st_d = sfc_pkg::SFC_STA;
			end else begin
				st_d = sfc_pkg::SFC_HDR;
			end
		end else begin
			case (st_q)
				sfc_pkg::SFC_HDR: begin
					sh_d = {sh_q[5:0], d_q};
					crc_d = sfc_pkg::crc4_step(crc_q, d_q);
					cnt_d = cnt_q + 3'h1;
					if (cnt_q == 3'(sfc_pkg::HDR_BITS - 2)) begin
						len_d = {sh_q[5:0], d_q};
						st_d = sfc_pkg::SFC_CAL;
					end
				end
				sfc_pkg::SFC_CAL: begin
					pay_d[idx_q[5:0]] = d_q;
					crc_d = sfc_pkg::crc4_step(crc_q, d_q);
					idx_d = idx_q + 7'h01;
					if (idx_q == len_q || idx_q[5:0] == 6'h3f) begin
						st_d = sfc_pkg::SFC_CRC;
						cnt_d = 3'h0;
						grp_d = idx_q[6];
						last_d = idx_q == len_q;
					end
				end
				sfc_pkg::SFC_STA: begin
					sh_d = {sh_q[5:0], d_q};
					crc_d = sfc_pkg::crc4_step(crc_q, d_q);
					cnt_d = cnt_q + 3'h1;
					if (cnt_q == 3'(sfc_pkg::STA_BITS - 2)) begin
						st_d = sfc_pkg::SFC_CRC;
						cnt_d = 3'h0;
						last_d = 1'b1;
					end
				end
				sfc_pkg::SFC_CRC: begin
					rc_d = {rc_q[1:0], d_q};
					cnt_d = cnt_q + 3'h1;
					if (cnt_q == 3'(sfc_pkg::CRC_W - 1)) begin
						emit_d = 1'b1;
						crc_ok_d = {rc_q, d_q} == crc_q;
						crc_d = sfc_pkg::CRC_INIT;
						if (last_q) begin
							st_d = sfc_pkg::SFC_HUNT;
							expect_d = 1'b1;
						end else begin
							st_d = sfc_pkg::SFC_CAL;
						end
					end
				end
				default: begin
					st_d = sfc_pkg::SFC_HUNT;
				end
			endcase
		end
	end

	always_ff @(posedge link_clock_i) begin
		if (!rst_n_q) begin
			st_q <= sfc_pkg::SFC_HUNT;
			cnt_q <= 3'h0;
			idx_q <= 7'h00;
			len_q <= 7'h00;
			sh_q <= 7'h00;
			rc_q <= 3'h0;
			crc_q <= sfc_pkg::CRC_INIT;
			pay_q <= 64'h0;
			expect_q <= 1'b0;
			aligned_q <= 1'b0;
			grp_q <= 1'b0;
			last_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			idx_q <= idx_d;
			len_q <= len_d;
			sh_q <= sh_d;
			rc_q <= rc_d;
			crc_q <= crc_d;
			pay_q <= pay_d;
			expect_q <= expect_d;
			aligned_q <= aligned_d;
			grp_q <= grp_d;
			last_q <= last_d;
		end
	end

	// word hand-over; a word finished while the last is unacked is dropped
	always_ff @(posedge link_clock_i) begin
		if (!rst_n_q) begin
			req_toggle_o <= 1'b0;
			ovf_toggle_o <= 1'b0;
			w_kind_o <= 1'b0;
			w_last_o <= 1'b0;
			w_grp_o <= 1'b0;
			w_crc_ok_o <= 1'b0;
			w_aligned_o <= 1'b0;
			w_payload_o <= 64'h0;
			w_len_o <= 7'h00;
			w_intf_o <= 1'b0;
			w_lanes_o <= 4'h0;
		end else if (emit_d && busy_w) begin
			ovf_toggle_o <= !ovf_toggle_o;
		end else if (emit_d) begin
			req_toggle_o <= !req_toggle_o;
			w_kind_o <= sta_q;
			w_last_o <= last_q;
			w_grp_o <= grp_q;
			w_crc_ok_o <= crc_ok_d;
			w_aligned_o <= aligned_q;
			w_payload_o <= pay_q;
			w_len_o <= len_q;
			w_intf_o <= sh_q[4];
			w_lanes_o <= sh_q[3:0];
		end
	end
	always_ff @(posedge link_clock_i) begin
		if (!rst_n_q) begin
			sta_q <= 1'b0;
		end else if (s_q) begin
			sta_q <= d_q == sfc_pkg::KIND_STA;
		end
	end
endmodule
`default_nettype wire

/* design/sfc_rx_deser_fix.sv */
// intentionally empty: holds no module
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* tb/sfc_link_partner.sv */
// far end model: sends calendar and status frames on the receive link
`timescale 1ns/1ps
`default_nettype none
module sfc_link_partner (
	output logic clk_o,
	output logic dat_o,
	output logic syn_o
);
	logic [3:0] c;
	initial begin
		clk_o = 1'b0;
		dat_o = 1'b0;
		syn_o = 1'b0;
	end
	// clock runs only while a bit is sent
	task automatic drv(input logic d, input logic s);
		dat_o = d;
		syn_o = s;
		#32 clk_o = 1'b1;
		#32 clk_o = 1'b0;
	endtask
	task automatic put(input logic d, input logic s);
		drv(d, s);
		c = {c[2:0], 1'b0} ^ ((c[3] ^ d) ? 4'h3 : 4'h0);
	endtask
	task automatic crc(input logic bad);
		logic [3:0] v;
		v = c ^ {3'h0, bad};
		for (int j = 3; j >= 0; j--) drv(v[j], 1'b0);
		c = 4'hf;
	endtask
	task automatic frame(input logic kind, input logic [127:0] fc,
		input logic [6:0] n, input logic [4:0] st, input logic bad);
		c = 4'hf;
		put(kind, 1'b1);
		if (kind) for (int i = 4; i >= 0; i--) put(st[i], 1'b0);
		else for (int i = 6; i >= 0; i--) put(n[i], 1'b0);
		for (int i = 0; !kind && i <= n; i++) begin
			put(fc[i], 1'b0);
			if (i % 64 == 63 || i == n) crc(bad);
		end
		if (kind) crc(bad);
		// one idle bit so the receiver finishes the last word
		drv(1'b0, 1'b0);
		// released lines show the inverse
		dat_o = ~dat_o;
		syn_o = ~syn_o;
	endtask
endmodule
`default_nettype wire

/* tb/sfc_sideband_flow_control_tb_top.sv */
// testbench top: drives both halves, scoreboard on received groups
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; \
	if ((g) !== (e)) begin n_mismatch++; \
	$display("BAD %s exp %h got %h", nm, (e), (g)); end end
module sfc_sideband_flow_control_tb_top;
	logic         clk = 1'b0;
	logic         rstn, txi, frc, sb_on;
	logic [127:0] txf, rxf, a, b;
	logic [1:0]   txu, rxu;
	logic [6:0]   txl, rxl, tx_len;
	logic [3:0]   txs, rxs;
	logic         ltc, ltd, lts, lrc, lrd, lrs;
	logic         rce, rov, rxi, rin, tx_typ, tx_b2b, tx_e0;
	logic [7:0]   tx_idx;
	logic [135:0] q[$];
	logic [135:0] nt;
	int           checks, n_mismatch, k, tx_nsta;
	always #12.5 clk = ~clk;
	sfc_sideband_flow_control u_dut (
		.CLOCK_I(clk), .RESETN_I(rstn),
		.TX_FLOW_BITS_I(txf), .TX_UPDATE_I(txu),
		.TX_CALENDAR_LENGTH_M1_I(txl), .TX_INTF_STATUS_I(txi),
		.TX_LANE_STATUS_I(txs), .LINK_TX_CLOCK_O(ltc),
		.LINK_TX_SERIAL_DATA_O(ltd), .LINK_TX_FRAME_SYNC_O(lts),
		.LINK_RX_CLOCK_I(lrc), .LINK_RX_SERIAL_DATA_I(lrd),
		.LINK_RX_FRAME_SYNC_I(lrs), .RX_FORCE_OFF_ON_CRCERR_I(frc),
		.RX_FLOW_BITS_O(rxf), .RX_CRC_ERROR_O(rce), .RX_OVERFLOW_O(rov),
		.RX_INTF_STATUS_O(rxi), .RX_LANE_STATUS_O(rxs),
		.RX_UPDATE_O(rxu), .RX_CALENDAR_LENGTH_M1_O(rxl),
		.RX_INITIALIZED_O(rin)
	);
	sfc_link_partner u_lp (.clk_o(lrc), .dat_o(lrd), .syn_o(lrs));
	// decode the transmit link
	always @(posedge ltc) begin
		if (lts) begin
			tx_b2b <= tx_b2b | (ltd & tx_typ);
			tx_typ <= ltd;
			tx_idx <= 8'd1;
			tx_nsta <= tx_nsta + int'(ltd);
		end else begin
			tx_idx <= tx_idx + 8'd1;
			if (!tx_typ && tx_idx < 8'd8) tx_len <= {tx_len[5:0], ltd};
			if (!tx_typ && tx_idx == 8'd8) tx_e0 <= ltd;
		end
	end
	// scoreboard: one note per group update pulse
	always @(negedge clk) if (sb_on) for (int g = 0; g < 2; g++)
		if (rxu[g] === 1'b1) begin
			nt = (q.size() == 0) ? '1 : q.pop_front();
			`CHK("grp", nt[128], 1'(g))
			`CHK("flow", nt[63:0], rxf[64*g +: 64] & nt[127:64])
			`CHK("len", nt[135:129], rxl)
		end
	task automatic w(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic cal(input logic [127:0] d, input logic [6:0] m,
		input logic bad, input logic on);
		logic [63:0] mk;
		mk = (m > 7'd63) ? '1 : (64'h1 << (m + 7'd1)) - 64'h1;
		if (on) q.push_back({m, 1'b0, mk, d[63:0] & mk});
		if (on && m > 7'd63) q.push_back({m, 1'b1, {64{1'b1}}, d[127:64]});
		u_lp.frame(1'b0, d, m, 5'h00, bad);
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#1000000;
		n_mismatch++;
		print_verdict;
	end
	initial begin
		rstn = 1'b0;
		{txf, txu, txl, txi, txs} = {128'h0, 2'h0, 7'h09, 1'b1, 4'hf};
		{frc, sb_on, tx_typ, tx_b2b, checks, n_mismatch, tx_nsta} = '0;
		k = $urandom(79578);
		fork
			u_lp.frame(1'b1, '0, 7'h00, 5'h1f, 1'b0);
			w(20);
		join
		w(1);
		rstn = 1'b1;
		`CHK("init", 1'b0, rin)
		`CHK("rxflow", 128'h0, rxf)
		k = 0;
		while (lts !== 1'b1 && k < 10) begin
			@(posedge clk);
			#1 k++;
		end
		`CHK("txstart", 4, k)
		w(1);
		txf = {$urandom, $urandom, $urandom, $urandom};
		a = txf;
		txu = 2'b11;
		w(1);
		txu = 2'b00;
		w(300);
		{tx_nsta, tx_b2b} = '0;
		w(300);
		`CHK("txlen", 7'h09, tx_len)
		`CHK("txe0", a[0], tx_e0)
		`CHK("txsta", 0, tx_nsta)
		txf[0] = ~a[0];
		txu = 2'b10;
		w(1);
		txu = 2'b00;
		w(300);
		`CHK("txhold", a[0], tx_e0)
		txs = 4'he;
		txu = 2'b01;
		w(1);
		txu = 2'b00;
		w(100);
		{tx_nsta, tx_b2b} = '0;
		w(400);
		`CHK("txnew", ~a[0], tx_e0)
		`CHK("txsta", 1'b1, tx_nsta > 0)
		`CHK("txalt", 1'b0, tx_b2b)
		for (int i = 0; i < 8; i++)
			cal({$urandom, $urandom, $urandom, $urandom}, 7'h0f, 0, 0);
		w(10);
		`CHK("init", 1'b1, rin)
		`CHK("intf", 1'b1, rxi)
		`CHK("lanes", 4'hf, rxs)
		sb_on = 1'b1;
		for (int i = 0; i < 2; i++) cal({$urandom, $urandom, $urandom,
			$urandom}, i ? 7'($urandom_range(62)) : 7'h7f, 0, 1);
		w(10);
		`CHK("sbq", 0, q.size())
		sb_on = 1'b0;
		u_lp.frame(1'b1, '0, 7'h00, 5'h1b, 1'b0);
		w(10);
		`CHK("sflow", 128'h0, rxf)
		`CHK("slane", 4'hb, rxs)
		b = {$urandom, $urandom, $urandom, $urandom};
		cal(b, 7'h7f, 0, 0);
		cal(b, 7'h7f, 0, 0);
		w(10);
		`CHK("hlane", 4'hf, rxs)
		`CHK("hflow", b, rxf)
		cal(~b, 7'h7f, 1, 0);
		w(10);
		`CHK("crcerr", 1'b1, rce)
		`CHK("crcflow", b, rxf)
		frc = 1'b1;
		w(4);
		`CHK("force", 128'h0, rxf)
		frc = 1'b0;
		w(4);
		`CHK("unforce", b, rxf)
		cal(b, 7'h7f, 0, 0);
		w(10);
		`CHK("crcclr", 1'b0, rce)
		`CHK("ovf", 1'b0, rov)
		print_verdict;
	end
endmodule
`default_nettype wire
